/* core/bfs_pkg.sv */
/*
 * Package for the breaker failure supervisor: register map, field layout,
 * reset values, scheme and trigger encodings, timebase constants.
 * Assumes a single 25 MHz system clock.
 */
package bfs_pkg;

	localparam int unsigned CLK_HZ = 25_000_000;
	// Timebase tick in microseconds; the supervision time counts these ticks
	localparam int unsigned TICK_US = 1000;
	localparam int unsigned TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
	localparam int unsigned TICK_W = 15;

	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_TIME = 4'h1;
	localparam logic [3:0] REG_THR_SET0 = 4'h2;
	localparam logic [3:0] REG_THR_SET1 = 4'h3;
	localparam logic [3:0] REG_THR_SET2 = 4'h4;
	localparam logic [3:0] REG_THR_SET3 = 4'h5;
	localparam logic [3:0] REG_STATUS = 4'h6;
	localparam logic [3:0] REG_ACK = 4'h7;

	// Control register fields
	localparam int unsigned CTRL_SCHEME_LSB = 0;
	localparam int unsigned CTRL_TRIGSRC_LSB = 2;
	localparam int unsigned CTRL_EXTRA_EN_LSB = 4;
	localparam int unsigned CTRL_SET_LSB = 8;

	localparam logic [15:0] TIME_RESET = 16'h0064;
	localparam logic [15:0] THR_RESET = 16'h0100;

	typedef enum logic [1:0] {
		SCHEME_CURRENT = 2'b00,
		SCHEME_POSITION = 2'b01,
		SCHEME_COMBINED = 2'b10
	} bfs_scheme_type;

	typedef enum logic [1:0] {
		TRIG_NONE = 2'b00,
		TRIG_ALL = 2'b01,
		TRIG_EXTERNAL = 2'b10,
		TRIG_CURRENT = 2'b11
	} bfs_trigsrc_type;

	typedef enum logic [1:0] {
		ST_STANDBY = 2'b00,
		ST_RUNNING = 2'b01,
		ST_REJECTED = 2'b10,
		ST_TRIPPED = 2'b11
	} bfs_state_type;

	// Routed trip signals from the trip manager, each already routed to this breaker
	typedef struct packed {
		logic external_trip;
		logic current_trip;
		logic other_trip;
	} bfs_trips_type;

	typedef struct packed {
		logic [15:0] current;
		logic pos_open;
		logic pos_closed;
	} bfs_meas_type;

endpackage

/* core/bfs_supervisor.sv */
/*
 * Breaker failure supervisor with an Avalon-MM register slave.
 * Assumes trips and breaker position come from pins (resynchronised here)
 * and phase current magnitude arrives from logic on the same clock.
 */
// Behaviour
// - Any selected trigger starts the timer; it keeps running if the trigger drops.
// - Timer reaching supervision time without detected opening asserts backup trip.
// - Detected opening per scheme (current, position, or either one) stops the timer.
// - After a stop the block stays rejected while any trigger remains active.
// - Opening detected while triggers still active enters the rejected state.
// - All triggers gone returns the block to stand-by.
// - Lockout flag sets with backup trip and holds until operator acknowledge.
// - Three extra trigger inputs start the timer regardless of routing.
// - Source all trips: every routed trip starts the supervisor.
// - Source external trips: only routed external trips start it.
// - Source current trips: only routed current trips start it.
// - Source none: only the three extra trigger inputs start it.
// - Current below threshold with breaker open gives no pickup.
// - Delay from trigger to backup trip equals the programmed supervision time.
// - Current scheme: failure when current stays above threshold until expiry.
// - Position scheme: failure when indicators never show open before expiry.
// - Combined scheme: failure only if current high and position not open together.
// - Threshold chosen per active parameter set; scheme is one global setting.
`timescale 1ns/10ps

module bfs_supervisor
	import bfs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic avs_response_err,
	input wire bfs_trips_type routed_trips,
	input wire logic extra_trigger_input_a,
	input wire logic extra_trigger_input_b,
	input wire logic extra_trigger_input_c,
	input wire bfs_meas_type meas,
	input wire logic operator_ack,
	output logic backup_trip,
	output logic lockout_flag,
	output logic supervisor_active
);

	localparam int unsigned NSYNC = 8;

	logic [1:0] scheme_q;
	logic [1:0] trigsrc_q;
	logic [2:0] extra_en_q;
	logic [1:0] set_sel_q;
	logic [15:0] sup_time_q;
	logic [15:0] thr_q [4];
	bfs_state_type state_q;
	logic [15:0] elapsed_q;
	logic [TICK_W-1:0] tick_cnt_q;
	logic backup_trip_q;
	logic lockout_q;
	logic ack_pulse;
	logic ack_pin_prev_q;
	logic rd_phase_q;
	logic [31:0] rdata_q;
	logic err_q;

	// Three-stage resynchronisers for pin inputs; change accepted when stages 2 and 3 agree
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] s1_q;
	logic [NSYNC-1:0] s2_q;
	logic [NSYNC-1:0] s3_q;
	logic [NSYNC-1:0] clean_q;

	assign pin_raw = {operator_ack, meas.pos_closed, meas.pos_open, extra_trigger_input_c,
		extra_trigger_input_b, extra_trigger_input_a, routed_trips.external_trip,
		routed_trips.current_trip ^ 1'b0};

	logic other_s1_q;
	logic other_s2_q;
	logic other_s3_q;
	logic other_clean_q;

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
					s3_q[gi] <= 1'b0;
					clean_q[gi] <= 1'b0;
				end else begin
					s1_q[gi] <= pin_raw[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					if (s2_q[gi] == s3_q[gi]) begin
						clean_q[gi] <= s3_q[gi];
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			other_s1_q <= 1'b0;
			other_s2_q <= 1'b0;
			other_s3_q <= 1'b0;
			other_clean_q <= 1'b0;
		end else begin
			other_s1_q <= routed_trips.other_trip;
			other_s2_q <= other_s1_q;
			other_s3_q <= other_s2_q;
			if (other_s2_q == other_s3_q) begin
				other_clean_q <= other_s3_q;
			end
		end
	end

	logic trip_cur;
	logic trip_ext;
	logic [2:0] extra_in;
	logic pos_open;
	logic pos_closed;
	logic ack_pin;
	assign trip_cur = clean_q[0];
	assign trip_ext = clean_q[1];
	assign extra_in = clean_q[4:2];
	assign pos_open = clean_q[5];
	assign pos_closed = clean_q[6];
	assign ack_pin = clean_q[7];

	// Trigger selection
	logic routed_trigger;
	logic any_trigger;
	always_comb begin
		unique case (bfs_trigsrc_type'(trigsrc_q))
			TRIG_ALL: routed_trigger = trip_cur | trip_ext | other_clean_q;
			TRIG_EXTERNAL: routed_trigger = trip_ext;
			TRIG_CURRENT: routed_trigger = trip_cur;
			TRIG_NONE: routed_trigger = 1'b0;
		endcase
	end
	assign any_trigger = routed_trigger | (|(extra_in & extra_en_q));

	// Opening detection per scheme
	logic [15:0] active_thr;
	logic current_low;
	logic position_shows_open;
	logic opening_detected;
	assign active_thr = thr_q[set_sel_q];
	assign current_low = meas.current < active_thr;
	// Both indicators must agree; an intermediate or faulty position is not open
	assign position_shows_open = pos_open & ~pos_closed;
	always_comb begin
		unique case (scheme_q)
			SCHEME_CURRENT: opening_detected = current_low;
			SCHEME_POSITION: opening_detected = position_shows_open;
			SCHEME_COMBINED: opening_detected = current_low | position_shows_open;
			default: opening_detected = current_low;
		endcase
	end

	// Fixed timebase tick, counting only in the running state and held at zero otherwise
	logic tick;
	assign tick = (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tick_cnt_q <= '0;
		end else if (tick || state_q != ST_RUNNING) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + TICK_W'(1);
		end
	end

	// Supervision state machine
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_STANDBY;
			elapsed_q <= '0;
		end else begin
			unique case (state_q)
				ST_STANDBY: begin
					elapsed_q <= '0;
					if (any_trigger) begin
						state_q <= ST_RUNNING;
					end
				end
				ST_RUNNING: begin
					// Trigger dropping does not stop the timer
					if (opening_detected) begin
						state_q <= any_trigger ? ST_REJECTED : ST_STANDBY;
					end else if (elapsed_q >= sup_time_q) begin
						state_q <= ST_TRIPPED;
					end else if (tick) begin
						elapsed_q <= elapsed_q + 16'h0001;
					end
				end
				ST_REJECTED: begin
					if (!any_trigger) begin
						state_q <= ST_STANDBY;
					end
				end
				ST_TRIPPED: begin
					if (!any_trigger) begin
						state_q <= ST_STANDBY;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			backup_trip_q <= 1'b0;
		end else begin
			backup_trip_q <= (state_q == ST_RUNNING) && !opening_detected
				&& (elapsed_q >= sup_time_q) || (state_q == ST_TRIPPED && any_trigger);
		end
	end

	// Lockout: set wins over a simultaneous acknowledge
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lockout_q <= 1'b0;
			ack_pin_prev_q <= 1'b0;
		end else begin
			ack_pin_prev_q <= ack_pin;
			if (state_q == ST_RUNNING && !opening_detected && elapsed_q >= sup_time_q) begin
				lockout_q <= 1'b1;
			end else if (ack_pulse) begin
				lockout_q <= 1'b0;
			end
		end
	end

	// Register bus: one wait cycle on reads, writes complete immediately
	logic bus_wr;
	logic ack_by_sw;
	assign bus_wr = avs_write && !avs_read;
	assign ack_by_sw = bus_wr && avs_address == REG_ACK && avs_byteenable[0] && avs_writedata[0];
	assign ack_pulse = ack_by_sw | (ack_pin & ~ack_pin_prev_q);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scheme_q <= 2'b00;
			trigsrc_q <= 2'b01;
			extra_en_q <= 3'b000;
			set_sel_q <= 2'b00;
			sup_time_q <= TIME_RESET;
			for (int i = 0; i < 4; i++) begin
				thr_q[i] <= THR_RESET;
			end
		end else if (bus_wr && avs_byteenable[0]) begin
			if (avs_address == REG_CTRL) begin
				scheme_q <= avs_writedata[CTRL_SCHEME_LSB +: 2] == 2'b11 ? 2'b10
					: avs_writedata[CTRL_SCHEME_LSB +: 2];
				trigsrc_q <= avs_writedata[CTRL_TRIGSRC_LSB +: 2];
				extra_en_q <= avs_writedata[CTRL_EXTRA_EN_LSB +: 3];
			end
			if (avs_address == REG_TIME && avs_byteenable[1]) begin
				sup_time_q <= avs_writedata[15:0];
			end
			for (int i = 0; i < 4; i++) begin
				if (avs_address == REG_THR_SET0 + 4'(i) && avs_byteenable[1]) begin
					thr_q[i] <= avs_writedata[15:0];
				end
			end
		end else if (bus_wr && avs_byteenable[1] && avs_address == REG_CTRL) begin
			set_sel_q <= avs_writedata[CTRL_SET_LSB +: 2];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd_phase_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
		end else begin
			rd_phase_q <= avs_read && !rd_phase_q;
			if (avs_read && !rd_phase_q) begin
				err_q <= avs_address > REG_ACK;
				unique case (avs_address)
					REG_CTRL: rdata_q <= {22'h0, set_sel_q, 1'b0, extra_en_q, trigsrc_q, scheme_q};
					REG_TIME: rdata_q <= {16'h0000, sup_time_q};
					REG_THR_SET0: rdata_q <= {16'h0000, thr_q[0]};
					REG_THR_SET1: rdata_q <= {16'h0000, thr_q[1]};
					REG_THR_SET2: rdata_q <= {16'h0000, thr_q[2]};
					REG_THR_SET3: rdata_q <= {16'h0000, thr_q[3]};
					REG_STATUS: rdata_q <= {10'h000, elapsed_q, 1'b0, any_trigger,
						lockout_q, backup_trip_q, state_q};
					default: rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign avs_waitrequest = avs_read && !rd_phase_q;
	assign avs_readdata = rdata_q;
	assign avs_response_err = err_q;
	assign backup_trip = backup_trip_q;
	assign lockout_flag = lockout_q;
	assign supervisor_active = state_q == ST_RUNNING;

endmodule

/* verif/bfs_far_side.sv */
/*
 * Far side model: trip manager levels, extra triggers, phase current, breaker position.
 * Assumes the bench changes the commands just after rising clock edges.
 */
`timescale 1ns/10ps
module bfs_far_side
	import bfs_pkg::*;
(
	input wire bfs_trips_type trips_cmd,
	input wire logic [2:0] extra_cmd,
	input wire logic cur_low,
	input wire logic pos_open_cmd,
	output bfs_trips_type routed_trips,
	output logic [2:0] extra_trig,
	output bfs_meas_type meas
);
	// Indicators stay complementary; a faulty indicator pair is not modelled
	always_comb begin
		routed_trips = trips_cmd;
		extra_trig = extra_cmd;
		meas.current = cur_low ? 16'h0010 : 16'h0400;
		meas.pos_open = pos_open_cmd;
		meas.pos_closed = !pos_open_cmd;
	end
endmodule

/* verif/bfs_sup_asserts.sv */
/*
 * Port checker for bfs_supervisor.
 * Assumes the bind at the foot and the reset threshold left in place.
 */
`timescale 1ns/10ps
module bfs_sup_asserts
	import bfs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic avs_write,
	input wire bfs_trips_type routed_trips,
	input wire logic extra_trigger_input_a,
	input wire logic extra_trigger_input_b,
	input wire logic extra_trigger_input_c,
	input wire bfs_meas_type meas,
	input wire logic operator_ack,
	input wire logic backup_trip,
	input wire logic lockout_flag,
	input wire logic supervisor_active
);
	logic [3:0] trig_age_q;
	wire logic opn = meas.current < THR_RESET && meas.pos_open && !meas.pos_closed;
	wire logic trig = |routed_trips | extra_trigger_input_a | extra_trigger_input_b
		| extra_trigger_input_c;
	// Age of the last raw trigger; the pins pass a synchroniser first
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			trig_age_q <= 4'hf;
		end else if (trig) begin
			trig_age_q <= 4'h0;
		end else if (trig_age_q != 4'hf) begin
			trig_age_q <= trig_age_q + 4'h1;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_rst_clear: assert property (disable iff (1'b0) rst |-> !backup_trip && !lockout_flag)
		else $error("output set during reset");
	a_trip_locks: assert property ($rose(backup_trip) |-> lockout_flag)
		else $error("lockout missing with backup trip");
	a_lock_holds: assert property ((lockout_flag && !operator_ack && !avs_write)[*6] |=> lockout_flag)
		else $error("lockout dropped without acknowledge");
	a_ack_clears: assert property ($rose(operator_ack) ##0 (operator_ack && !backup_trip)[*3]
		##1 (!backup_trip)[*6] |-> !lockout_flag)
		else $error("lockout not cleared by acknowledge");
	a_trip_ran: assert property ($rose(backup_trip) |-> $past(supervisor_active))
		else $error("backup trip without running timer");
	a_start_cause: assert property ($rose(supervisor_active) |-> trig_age_q < 4'h8)
		else $error("timer started without trigger");
	a_open_stops: assert property (opn[*8] ##1 (opn && supervisor_active) |=> !supervisor_active)
		else $error("timer runs with breaker open");
	a_open_no_trip: assert property (opn[*8] |-> !$rose(backup_trip))
		else $error("pickup with breaker open");
endmodule

bind bfs_supervisor bfs_sup_asserts i_bfs_sup_asserts (
	.sys_clk(sys_clk), .rst(rst), .avs_write(avs_write), .routed_trips(routed_trips),
	.extra_trigger_input_a(extra_trigger_input_a), .extra_trigger_input_b(extra_trigger_input_b),
	.extra_trigger_input_c(extra_trigger_input_c), .meas(meas), .operator_ack(operator_ack),
	.backup_trip(backup_trip), .lockout_flag(lockout_flag), .supervisor_active(supervisor_active)
);

/* verif/tb.sv */
/*
 * Self-checking bench for bfs_supervisor with the far side model.
 * Assumes the package tick length; supervision time is cut to one tick.
 */
`timescale 1ns/10ps
module tb;
	import bfs_pkg::*;
	logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, avs_response_err, rd_e;
	logic [3:0] avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, rd_v;
	logic operator_ack, backup_trip, lockout_flag, supervisor_active, cur_low, pos_open_cmd;
	logic [2:0] extra_cmd, extra_trig;
	bfs_trips_type trips_cmd, routed_trips;
	bfs_meas_type meas;
	int n_mismatch = 0;
	int n_checks = 0;

	bfs_far_side i_bfs_far_side (.trips_cmd(trips_cmd), .extra_cmd(extra_cmd),
		.cur_low(cur_low), .pos_open_cmd(pos_open_cmd), .routed_trips(routed_trips),
		.extra_trig(extra_trig), .meas(meas));
	bfs_supervisor i_bfs_supervisor (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err),
		.routed_trips(routed_trips), .extra_trigger_input_a(extra_trig[0]),
		.extra_trigger_input_b(extra_trig[1]), .extra_trigger_input_c(extra_trig[2]),
		.meas(meas), .operator_ack(operator_ack), .backup_trip(backup_trip),
		.lockout_flag(lockout_flag), .supervisor_active(supervisor_active));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Request held until the rising edge that sees waitrequest low; data taken at that edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= w;
		avs_read <= !w;
		@(posedge sys_clk);
		while (avs_waitrequest) begin
			@(posedge sys_clk);
		end
		rd_v = avs_readdata;
		rd_e = avs_response_err;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic chk_st(input logic [1:0] e);
		repeat (8) @(posedge sys_clk);
		bus(1'b0, REG_STATUS, 32'h0, 4'hf);
		chk(32'(rd_v[1:0]), 32'(e));
	endtask

	task automatic t_regs;
		chk_st(2'd0);
		bus(1'b0, REG_TIME, 32'h0, 4'hf);
		chk(rd_v, {16'h0, TIME_RESET});
		bus(1'b0, REG_THR_SET2, 32'h0, 4'hf);
		chk(rd_v, {16'h0, THR_RESET});
		bus(1'b1, REG_CTRL, 32'h100, 4'h2);
		bus(1'b0, REG_CTRL, 32'h0, 4'hf);
		chk(32'(rd_v[9:8]), 32'h1);
		bus(1'b0, 4'h9, 32'h0, 4'hf);
		chk(rd_v, 32'h0);
		chk(32'(rd_e), 32'h1);
		$display("test regs done");
	endtask

	task automatic t_sources;
		cur_low <= 1'b1;
		pos_open_cmd <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			bus(1'b1, REG_CTRL, 32'(1 + 4 * s), 4'hf);
			for (int b = 0; b < 3; b++) begin
				trips_cmd <= bfs_trips_type'(3'(1 << b));
				chk_st((s == 1 || s == 4 - b) ? 2'd2 : 2'd0);
				trips_cmd <= '0;
				chk_st(2'd0);
			end
		end
		bus(1'b1, REG_CTRL, 32'h71, 4'hf);
		for (int b = 0; b < 3; b++) begin
			extra_cmd <= 3'(1 << b);
			chk_st(2'd2);
			extra_cmd <= 3'h0;
			chk_st(2'd0);
		end
		$display("test sources done");
	endtask

	task automatic t_schemes;
		pos_open_cmd <= 1'b0;
		for (int c = 0; c < 3; c++) begin
			bus(1'b1, REG_CTRL, 32'(c + 4), 4'hf);
			trips_cmd <= 3'b001;
			chk_st(c == 1 ? 2'd1 : 2'd2);
			chk(32'(supervisor_active), 32'(c == 1));
			pos_open_cmd <= 1'b1;
			chk_st(2'd2);
			trips_cmd <= '0;
			pos_open_cmd <= 1'b0;
			chk_st(2'd0);
		end
		$display("test schemes done");
	endtask

	task automatic t_trip;
		int n = 0;
		bus(1'b1, REG_TIME, 32'h1, 4'hf);
		bus(1'b1, REG_CTRL, 32'h4, 4'hf);
		cur_low <= 1'b0;
		trips_cmd <= 3'b100;
		repeat (3) @(posedge sys_clk);
		trips_cmd <= '0;
		while (!backup_trip && n < 60000) begin
			@(negedge sys_clk);
			n++;
		end
		chk(32'(n < 2 * TICK_CYCLES + 8), 32'h1);
		chk(32'(backup_trip), 32'h1);
		chk(32'(lockout_flag), 32'h1);
		@(posedge sys_clk);
		cur_low <= 1'b1;
		pos_open_cmd <= 1'b1;
		repeat (20) @(negedge sys_clk);
		chk(32'(lockout_flag), 32'h1);
		@(posedge sys_clk);
		operator_ack <= 1'b1;
		repeat (10) @(posedge sys_clk);
		operator_ack <= 1'b0;
		@(negedge sys_clk);
		chk(32'(lockout_flag), 32'h0);
		$display("test trip done");
	endtask

	initial begin
		rst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
		operator_ack = 1'b0;
		trips_cmd = '0;
		extra_cmd = 3'h0;
		cur_low = 1'b0;
		pos_open_cmd = 1'b0;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs;
		t_sources;
		t_schemes;
		t_trip;
		report_and_stop;
	end

	initial begin
		repeat (90000) @(posedge sys_clk);
		n_mismatch++;
		$display("Error at %0t: timeout", $time);
		report_and_stop;
	end
endmodule
